// File: verilog/acb_unit.sv
// Operation
// RL1: read-port bank 0 returns general inputs 0..3 as 0 or 1.
// RL2: bank 1 returns analog ports 0..2 in 0..4095, port 3 in 0..65535.
// RL3: analog lines readable as digital and analog, neither disturbing other; analog_chan_0/1 are read through bank 1 only.
// RL4: bank 2 returns driven state of outputs 0 and 1.
// RL5: math code 19 combines accumulator with operand, result to accumulator.
// RL6: math types 0..4 add, subtract, multiply, divide, modulo.
// RL7: types 5..7 and, or, xor; type 8 inverts accumulator.
// RL8: math type 9 loads operand into accumulator.
// RL9: direct math replies status 100 echoing operand.
// RL10: issuer supplies one operand in value, bank field ignored.
// RL11: test code 20 compares accumulator with operand, updates flags.
// RL12: branch code 21 loads program counter when condition holds.
// RL13: branch conditions 0..3 null, non-null, equal, not equal.
// RL14: branch conditions 4..7 greater, greater-equal, lower, lower-equal.
// RL15: branch conditions 8..11 test timeout, alarm, deviation, position.
// RL16: branch is only for stored programs, never sent directly.
// RL17: test is only issued from a stored program; a direct test frame is still executed, updating flags and replying OK.
// RL18: math is mainly used inside a stored program.
// RL19: frame is address, code, type, bank, value msb first, checksum.
// RL20: direct read-port replies OK with port state, accumulator untouched.
// RL21: checksum is byte sum of eight bytes; mismatching frames rejected.
// RL22: accumulator 32-bit two's complement; divide by zero keeps it.
//
// The register offsets and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module acb_unit
    import acb_pkg::*;
(
    input  logic        core_clk,
    input  logic        rst,
    input  logic [7:0]  avs_address,
    input  logic        avs_read,
    input  logic        avs_write,
    input  logic [31:0] avs_writedata,
    input  logic [3:0]  avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic        avs_waitrequest,
    input  logic        gen_input_0,
    input  logic        gen_input_1,
    input  logic        gen_input_2,
    input  logic        gen_input_3,
    input  logic [11:0] analog_chan_0,
    input  logic [11:0] analog_chan_1,
    input  logic [11:0] supply_voltage_sample,
    input  logic [15:0] temp_sample,
    input  logic        cond_timeout_fault,
    input  logic        cond_outside_alarm,
    input  logic        cond_deviation_fault,
    input  logic        cond_position_fault,
    output logic        gen_output_0,
    output logic        gen_output_1
);
    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic acb_word_t acb_merge(input acb_word_t old,
                                            input acb_word_t nw,
                                            input logic [3:0] be);
        acb_word_t r;
        for (int i = 0; i < 4; i++)
        begin
            r[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
        return r;
    endfunction

    // byte sum of the eight frame bytes ahead of the checksum
    function automatic logic [7:0] acb_sum8(input acb_word_t h,
                                            input acb_word_t v);
        return h[31:24] + h[23:16] + h[15:8] + h[7:0]
             + v[31:24] + v[23:16] + v[15:8] + v[7:0]; // RL21
    endfunction

    function automatic acb_word_t acb_accum_math_cmd(input logic [7:0] t,
                                           input acb_word_t a,
                                           input acb_word_t b);
        acb_word_t r;
        r = a;
        case (t)
            `ACB_M_ADD:  r = a + b; // RL6
            `ACB_M_SUB:  r = a - b;
            `ACB_M_MUL:  r = a * b;
            `ACB_M_DIV:  if (b != 32'h00000000)
                             r = acb_word_t'($signed(a) / $signed(b)); // RL22
            `ACB_M_MOD:  if (b != 32'h00000000)
                             r = acb_word_t'($signed(a) % $signed(b)); // RL22
            `ACB_M_AND:  r = a & b; // RL7
            `ACB_M_OR:   r = a | b;
            `ACB_M_XOR:  r = a ^ b;
            `ACB_M_NOT:  r = ~a;
            `ACB_M_LOAD: r = b; // RL8
            default:     r = a;
        endcase
        return r;
    endfunction

    // flags: bit0 null, bit1 same, bit2 above, bit3 below
    function automatic logic acb_cond(input logic [7:0] t,
                                      input logic [3:0] f,
                                      input logic [3:0] flt);
        logic hit;
        hit = 1'b0;
        case (t)
            `ACB_C_NULL:     hit = f[0]; // RL13
            `ACB_C_NONNULL:  hit = ~f[0];
            `ACB_C_SAME:     hit = f[1];
            `ACB_C_DIFFER:   hit = ~f[1];
            `ACB_C_ABOVE:    hit = f[2]; // RL14
            `ACB_C_ABOVE_EQ: hit = f[2] | f[1];
            `ACB_C_BELOW:    hit = f[3];
            `ACB_C_BELOW_EQ: hit = f[3] | f[1];
            `ACB_C_TIMEOUT:  hit = flt[0]; // RL15
            `ACB_C_ALARM:    hit = flt[1];
            `ACB_C_DEVIATE:  hit = flt[2];
            `ACB_C_POSITION: hit = flt[3];
            default:         hit = 1'b0;
        endcase
        return hit;
    endfunction

    // top bit flags a port that exists
    function automatic logic [32:0] acb_port(input logic [7:0] bank,
                                             input logic [7:0] port,
                                             input logic [3:0] din,
                                             input logic [1:0] dout);
        logic [32:0] r;
        r = 33'h0;
        if (bank == `ACB_BANK_DIN && port < 8'h04)
            r = {1'b1, 31'h00000000, din[port[1:0]]}; // RL1
        else if (bank == `ACB_BANK_AIN && port == 8'h00)
            r = {1'b1, 20'h00000, analog_chan_0}; // RL2
        else if (bank == `ACB_BANK_AIN && port == 8'h01)
            r = {1'b1, 20'h00000, analog_chan_1};
        else if (bank == `ACB_BANK_AIN && port == 8'h02)
            r = {1'b1, 20'h00000, supply_voltage_sample};
        else if (bank == `ACB_BANK_AIN && port == 8'h03)
            r = {1'b1, 16'h0000, temp_sample};
        else if (bank == `ACB_BANK_DOUT && port < 8'h02)
            r = {1'b1, 31'h00000000, dout[port[0]]}; // RL4
        return r;
    endfunction

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [7:0]  s1_r, s2_r, s3_r, pin_r;
    logic        ack_r, stall, commit;
    acb_word_t   hdr_r, val_r, acc_r, acc_nxt, rval_r, rval_nxt;
    logic        chk_ok_r, pending_r, run_r, done_r;
    logic [7:0]  stat_r, stat_nxt, echo_r;
    logic [3:0]  flags_r, flags_nxt;
    logic [1:0]  out_r, out_nxt;
    acb_pc_t     pc_r, pc_nxt, paddr_r;
    logic [23:0] phi_r;
    acb_inst_t   inst;
    acb_state_t  state_r;
    logic        go, direct;
    logic [7:0]  ex_op, ex_type, ex_bank;
    acb_word_t   ex_val, rd_mux;
    logic [32:0] port_val;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // a pin change is taken only once stages two and three agree,
    // which also filters a single-cycle glitch
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s1_r  <= 8'h00;
            s2_r  <= 8'h00;
            s3_r  <= 8'h00;
            pin_r <= 8'h00;
        end
        else
        begin
            s1_r  <= {cond_position_fault, cond_deviation_fault,
                      cond_outside_alarm, cond_timeout_fault,
                      gen_input_3, gen_input_2, gen_input_1, gen_input_0};
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            if (s2_r == s3_r)
                pin_r <= s3_r;
        end
    end

    // ------------------------------------------------------------
    // avalon handshake
    // ------------------------------------------------------------
    // one wait cycle per access; a checksum write is held off while
    // the previous direct frame is still waiting to execute
    assign stall = avs_write && avs_address == `ACB_FRAME_CHK && pending_r;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign commit = avs_write & ack_r;

    always_ff @(posedge core_clk)
    begin
        if (rst)
            ack_r <= 1'b0;
        else
            ack_r <= (avs_read | avs_write) & ~ack_r & ~stall;
    end

    // read mux; unmapped offsets read as zero
    always_comb
    begin
        if (avs_address == `ACB_FRAME_HDR)
            rd_mux = hdr_r;
        else if (avs_address == `ACB_FRAME_VAL)
            rd_mux = val_r;
        else if (avs_address == `ACB_REPLY_STAT)
            rd_mux = {15'h0000, done_r, echo_r, stat_r};
        else if (avs_address == `ACB_REPLY_VAL)
            rd_mux = rval_r;
        else if (avs_address == `ACB_RUN_CTRL)
            rd_mux = {31'h00000000, run_r};
        else if (avs_address == `ACB_PROG_CNT)
            rd_mux = {24'h000000, pc_r};
        else if (avs_address == `ACB_PROG_ADDR)
            rd_mux = {24'h000000, paddr_r};
        else if (avs_address == `ACB_ACCUM)
            rd_mux = acc_r;
        else if (avs_address == `ACB_FLAGS)
            rd_mux = {28'h0000000, flags_r};
        else
            rd_mux = 32'h00000000;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            avs_readdata <= 32'h00000000;
        else if (avs_read & ~ack_r)
            avs_readdata <= rd_mux;
    end

    // ------------------------------------------------------------
    // direct frame registers
    // ------------------------------------------------------------
    // header holds address, code, type, bank; value is msb first
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            hdr_r    <= 32'h00000000;
            val_r    <= 32'h00000000;
            chk_ok_r <= 1'b0;
        end
        else if (commit)
        begin
            if (avs_address == `ACB_FRAME_HDR)
                hdr_r <= acb_merge(hdr_r, avs_writedata, avs_byteenable);
            if (avs_address == `ACB_FRAME_VAL)
                val_r <= acb_merge(val_r, avs_writedata, avs_byteenable);
            if (avs_address == `ACB_FRAME_CHK)
                chk_ok_r <= acb_sum8(hdr_r, val_r)
                            == avs_writedata[7:0]; // RL21
        end
    end

    // checksum write launches the frame
    always_ff @(posedge core_clk)
    begin
        if (rst)
            pending_r <= 1'b0;
        else if (commit && avs_address == `ACB_FRAME_CHK)
            pending_r <= 1'b1; // RL19
        else if (go && direct)
            pending_r <= 1'b0;
    end

    // ------------------------------------------------------------
    // stored program loading
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            paddr_r <= '0;
            phi_r   <= 24'h000000;
        end
        else if (commit && avs_address == `ACB_PROG_ADDR)
            paddr_r <= avs_writedata[`ACB_PC_W-1:0];
        else if (commit && avs_address == `ACB_PROG_HI)
            phi_r <= avs_writedata[23:0];
        else if (commit && avs_address == `ACB_PROG_LO)
            paddr_r <= paddr_r + acb_pc_t'(1);
    end

    acb_prog_mem u_mem (
        .core_clk (core_clk),
        .wr_en    (commit && avs_address == `ACB_PROG_LO),
        .wr_addr  (paddr_r),
        .wr_data  ({phi_r, avs_writedata}),
        .rd_addr  (pc_r),
        .rd_data  (inst)
    );

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // a waiting direct frame is served before the next program step
    always_ff @(posedge core_clk)
    begin
        if (rst)
            state_r <= acb_idle;
        else
            case (state_r)
                acb_idle:  if (!pending_r && run_r) state_r <= acb_fetch;
                acb_fetch: state_r <= acb_exec;
                acb_exec:  state_r <= acb_idle;
                default:   state_r <= acb_idle;
            endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            run_r <= 1'b0;
        else if (commit && avs_address == `ACB_RUN_CTRL)
            run_r <= avs_writedata[`ACB_RUN_BIT];
    end

    assign direct  = state_r == acb_idle;
    assign go      = (direct && pending_r) || state_r == acb_exec;
    assign ex_op   = direct ? hdr_r[23:16] : inst[55:48];
    assign ex_type = direct ? hdr_r[15:8]  : inst[47:40];
    assign ex_bank = direct ? hdr_r[7:0]   : inst[39:32];
    assign ex_val  = direct ? val_r        : inst[31:0];
    assign port_val = acb_port(ex_bank, ex_type, pin_r[3:0], out_r);

    // ------------------------------------------------------------
    // instruction execute
    // ------------------------------------------------------------
    always_comb
    begin
        acc_nxt   = acc_r;
        flags_nxt = flags_r;
        out_nxt   = out_r;
        pc_nxt    = pc_r + acb_pc_t'(1);
        stat_nxt  = `ACB_ST_OK;
        rval_nxt  = 32'h00000000;
        if (direct && !chk_ok_r)
            stat_nxt = `ACB_ST_BAD_CHK; // RL21
        else
            case (ex_op)
                `ACB_OP_DRIVE:
                    if (ex_bank == `ACB_BANK_DOUT && ex_type < 8'h02)
                        out_nxt[ex_type[0]] = ex_val[0];
                    else
                        stat_nxt = `ACB_ST_BAD_VAL;
                // digital and analog reads use separate paths
                `ACB_OP_READ:
                    if (port_val[32])
                    begin
                        rval_nxt = port_val[31:0]; // RL20 RL3
                        if (!direct)
                            acc_nxt = port_val[31:0];
                    end
                    else
                        stat_nxt = `ACB_ST_BAD_VAL;
                // math ignores the bank field
                `ACB_OP_MATH:
                    if (ex_type <= `ACB_M_LOAD)
                    begin
                        acc_nxt  = acb_accum_math_cmd(ex_type, acc_r, ex_val); // RL5
                        rval_nxt = ex_val; // RL9 RL10
                    end
                    else
                        stat_nxt = `ACB_ST_BAD_TYPE;
                `ACB_OP_TEST:
                    flags_nxt = {$signed(acc_r) < $signed(ex_val),
                                 $signed(acc_r) > $signed(ex_val),
                                 acc_r == ex_val,
                                 acc_r == 32'h00000000}; // RL11 RL17
                `ACB_OP_BRANCH:
                    if (direct)
                        stat_nxt = `ACB_ST_BAD_CMD; // RL16
                    else if (acb_cond(ex_type, flags_r, pin_r[7:4]))
                        pc_nxt = ex_val[`ACB_PC_W-1:0]; // RL12
                default:
                    stat_nxt = `ACB_ST_BAD_CMD;
            endcase
    end

    // state commits on every executed step
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            acc_r   <= `ACB_ACC_RST;
            flags_r <= 4'h0;
            out_r   <= 2'h0;
        end
        else if (go)
        begin
            acc_r   <= acc_nxt; // RL22 RL18
            flags_r <= flags_nxt;
            out_r   <= out_nxt;
        end
    end

    // program counter: execution outranks a software load
    always_ff @(posedge core_clk)
    begin
        if (rst)
            pc_r <= '0;
        else if (go && !direct)
            pc_r <= pc_nxt;
        else if (commit && avs_address == `ACB_PROG_CNT)
            pc_r <= avs_writedata[`ACB_PC_W-1:0];
    end

    // ------------------------------------------------------------
    // direct reply
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            stat_r <= 8'h00;
            echo_r <= 8'h00;
            rval_r <= 32'h00000000;
        end
        else if (go && direct)
        begin
            stat_r <= stat_nxt; // RL9
            echo_r <= ex_op;
            rval_r <= rval_nxt;
        end
    end

    // done flag: a new reply wins over a clear in the same cycle
    always_ff @(posedge core_clk)
    begin
        if (rst)
            done_r <= 1'b0;
        else if (go && direct)
            done_r <= 1'b1;
        else if (commit && avs_address == `ACB_REPLY_STAT
                 && avs_byteenable[2] && avs_writedata[`ACB_DONE_BIT])
            done_r <= 1'b0;
    end

    assign gen_output_0 = out_r[0];
    assign gen_output_1 = out_r[1];
endmodule

// File: verilog/acb_map.svh
`ifndef ACB_MAP_SVH
`define ACB_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ACB_FRAME_HDR   8'h00
`define ACB_FRAME_VAL   8'h04
`define ACB_FRAME_CHK   8'h08
`define ACB_REPLY_STAT  8'h0C
`define ACB_REPLY_VAL   8'h10
`define ACB_RUN_CTRL    8'h14
`define ACB_PROG_CNT    8'h18
`define ACB_PROG_ADDR   8'h1C
`define ACB_PROG_HI     8'h20
`define ACB_PROG_LO     8'h24
`define ACB_ACCUM       8'h28
`define ACB_FLAGS       8'h2C

// ----------------------------------------------------------------
// fields, widths, reset values
// ----------------------------------------------------------------
`define ACB_DONE_BIT    16
`define ACB_RUN_BIT     0
`define ACB_PC_W        8
`define ACB_PROG_DEPTH  256
`define ACB_MEM_W       56
`define ACB_ACC_RST     32'h00000000

// ----------------------------------------------------------------
// instruction codes
// ----------------------------------------------------------------
`define ACB_OP_DRIVE    8'h0E
`define ACB_OP_READ     8'h0F
`define ACB_OP_MATH     8'h13
`define ACB_OP_TEST     8'h14
`define ACB_OP_BRANCH   8'h15

// ----------------------------------------------------------------
// reply status codes
// ----------------------------------------------------------------
`define ACB_ST_OK       8'h64
`define ACB_ST_BAD_CHK  8'h01
`define ACB_ST_BAD_CMD  8'h02
`define ACB_ST_BAD_TYPE 8'h03
`define ACB_ST_BAD_VAL  8'h04

// ----------------------------------------------------------------
// port banks
// ----------------------------------------------------------------
`define ACB_BANK_DIN    8'h00
`define ACB_BANK_AIN    8'h01
`define ACB_BANK_DOUT   8'h02

// ----------------------------------------------------------------
// math types
// ----------------------------------------------------------------
`define ACB_M_ADD       8'h00
`define ACB_M_SUB       8'h01
`define ACB_M_MUL       8'h02
`define ACB_M_DIV       8'h03
`define ACB_M_MOD       8'h04
`define ACB_M_AND       8'h05
`define ACB_M_OR        8'h06
`define ACB_M_XOR       8'h07
`define ACB_M_NOT       8'h08
`define ACB_M_LOAD      8'h09

// ----------------------------------------------------------------
// branch conditions
// ----------------------------------------------------------------
`define ACB_C_NULL      8'h00
`define ACB_C_NONNULL   8'h01
`define ACB_C_SAME      8'h02
`define ACB_C_DIFFER    8'h03
`define ACB_C_ABOVE     8'h04
`define ACB_C_ABOVE_EQ  8'h05
`define ACB_C_BELOW     8'h06
`define ACB_C_BELOW_EQ  8'h07
`define ACB_C_TIMEOUT   8'h08
`define ACB_C_ALARM     8'h09
`define ACB_C_DEVIATE   8'h0A
`define ACB_C_POSITION  8'h0B

`endif

// File: verilog/acb_pkg.sv
package acb_pkg;
`include "acb_map.svh"
    typedef enum logic [1:0] {acb_idle, acb_fetch, acb_exec} acb_state_t;
    typedef logic [31:0]            acb_word_t;
    typedef logic [`ACB_PC_W-1:0]   acb_pc_t;
    typedef logic [`ACB_MEM_W-1:0]  acb_inst_t;
endpackage

// File: verilog/acb_prog_mem.sv
`timescale 1ns/1ns
module acb_prog_mem
    import acb_pkg::*;
(
    input  logic       core_clk,
    input  logic       wr_en,
    input  acb_pc_t    wr_addr,
    input  acb_inst_t  wr_data,
    input  acb_pc_t    rd_addr,
    output acb_inst_t  rd_data
);
    acb_inst_t mem_r [`ACB_PROG_DEPTH];

    // ------------------------------------------------------------
    // storage write port
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (wr_en)
        begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    // ------------------------------------------------------------
    // registered read, no reset so it maps onto block ram
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        rd_data <= mem_r[rd_addr];
    end
endmodule

// File: tb/acb_unit_chk.sv
`timescale 1ns/1ns
// ------------
// bus and reset checks
// ------------
module acb_unit_chk
(
    input logic        core_clk,
    input logic        rst,
    input logic [7:0]  avs_address,
    input logic        avs_read,
    input logic        avs_write,
    input logic [31:0] avs_readdata,
    input logic        avs_waitrequest
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // read taken here
    sequence rd_ack;
        avs_read && !avs_waitrequest;
    endsequence
    AST_NEW_WAIT: assert property ($rose(avs_read) |-> avs_waitrequest)
        else $error("read not waited");
    AST_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest
        |-> ##[1:4] !avs_waitrequest) else $error("no answer");
    AST_QUIET: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
        else $error("idle wait");
    AST_UNMAPPED: assert property (rd_ack ##0 (avs_address > 8'h2C)
        |-> avs_readdata == 32'h0) else $error("unmapped read");
    AST_WO_ZERO: assert property (rd_ack ##0 (avs_address == 8'h24)
        |-> avs_readdata == 32'h0) else $error("write-only read");
    AST_FLAGS_W: assert property (rd_ack ##0 (avs_address == 8'h2C)
        |-> avs_readdata[31:4] == 28'h0) else $error("flags too wide");
    AST_HOLD: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved");
    AST_OUT_RST: assert property ($fell(rst)
        |-> !avs_waitrequest && avs_readdata == 32'h0)
        else $error("bus after reset");
endmodule
bind acb_unit acb_unit_chk u_chk (.*);

// File: tb/acb_host.sv
`timescale 1ns/1ns
// ------------
// host model
// ------------
module acb_host
    import acb_pkg::*;
(
    input  logic       core_clk,
    input  logic       avs_waitrequest,
    input  acb_word_t  avs_readdata,
    output logic [7:0] avs_address = 8'h00,
    output logic       avs_read = 1'h0,
    output logic       avs_write = 1'h0,
    output acb_word_t  avs_writedata = 32'h0,
    output logic [3:0] avs_byteenable = 4'hF
);
    acb_word_t  st, q;
    logic [7:0] s;
    // held until waitrequest low
    task xf(input logic w, input logic [7:0] a, input acb_word_t d);
        @(posedge core_clk);
        {avs_address, avs_writedata, avs_write, avs_read} <= {a, d, w, !w};
        do
            @(posedge core_clk);
        while (avs_waitrequest !== 1'h0);
        q = avs_readdata;
        {avs_write, avs_read} <= 2'h0;
    endtask
    // k spoils the checksum
    task frame(input logic [7:0] c, t, b, input acb_word_t v,
               input logic [7:0] k);
        s = 8'h01 + c + t + b + v[31:24] + v[23:16] + v[15:8] + v[7:0] + k;
        xf(1'h1, 8'h00, {8'h01, c, t, b});
        xf(1'h1, 8'h04, v);
        xf(1'h1, 8'h08, {24'h0, s});
        do
            xf(1'h0, 8'h0C, 32'h0);
        while (q[16] !== 1'h1);
        st = q & 32'hFF;
        xf(1'h1, 8'h0C, 32'h10000);
        xf(1'h0, 8'h10, 32'h0);
    endtask
    // program steps of any code go to memory
    task entry(input logic [7:0] c, t, input acb_word_t v);
        xf(1'h1, 8'h20, {8'h00, c, t, 8'h00});
        xf(1'h1, 8'h24, v);
    endtask
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ns
// ------------
// bench
// ------------
module tb_top
    import acb_pkg::*;
;
    logic core_clk = 1'h0, rst = 1'h1;
    logic gen_input_0 = 1'h0, gen_input_1 = 1'h1;
    logic gen_input_2 = 1'h0, gen_input_3 = 1'h1;
    logic [11:0] analog_chan_0 = 12'hABC, analog_chan_1 = 12'h123;
    logic [11:0] supply_voltage_sample = 12'hFFF;
    logic [15:0] temp_sample = 16'hFFFF;
    logic cond_timeout_fault = 1'h0, cond_outside_alarm = 1'h0;
    logic cond_deviation_fault = 1'h0, cond_position_fault = 1'h0;
    logic [7:0] avs_address;
    logic [3:0] avs_byteenable;
    logic avs_read, avs_write, avs_waitrequest, gen_output_0, gen_output_1;
    acb_word_t avs_writedata, avs_readdata;
    int error_cnt = 0, samples_checked = 0;
    acb_unit u_dut (.*);
    acb_host u_host (.*);
    // clock
    always #5 core_clk = ~core_clk;
    task chk(input string n, input acb_word_t s, e);
        samples_checked++;
        if (s !== e)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task test_done;
        if (error_cnt == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task t_math;
        acb_word_t ex[10] = '{-17, -23, -60, -6, -2, 0, -17, -17, 19, 3};
        for (int t = 0; t < 10; t++)
        begin
            u_host.frame(8'h13, 8'h09, 8'h00, -20, 8'h00);
            u_host.frame(8'h13, t[7:0], 8'h00, 32'h3, 8'h00);
            chk("status", u_host.st, 32'h64);
            chk("echo", u_host.q, 32'h3);
            u_host.xf(1'h0, 8'h28, 32'h0);
            chk("accum", u_host.q, ex[t]);
        end
        u_host.frame(8'h13, 8'h03, 8'h00, 32'h0, 8'h00);
        u_host.frame(8'h13, 8'h0A, 8'h00, 32'h5, 8'h00);
        chk("type", u_host.st, 32'h3);
        u_host.frame(8'h13, 8'h09, 8'h00, 32'h5, 8'h5A);
        chk("sum", u_host.st, 32'h1);
        u_host.frame(8'h15, 8'h00, 8'h00, 32'h0, 8'h00);
        chk("direct", u_host.st, 32'h2);
        u_host.xf(1'h1, 8'h30, 32'h5);
        u_host.xf(1'h0, 8'h24, 32'h0);
        u_host.xf(1'h0, 8'h30, 32'h0);
        u_host.xf(1'h0, 8'h28, 32'h0);
        chk("accum", u_host.q, 32'h3);
    endtask
    task t_ports;
        acb_word_t av[4] = '{12'hABC, 12'h123, 12'hFFF, 16'hFFFF};
        for (int p = 0; p < 4; p++)
        begin
            u_host.frame(8'h0F, p[7:0], 8'h00, 32'h0, 8'h00);
            chk("din", u_host.q, (4'hA >> p) & 32'h1);
            u_host.frame(8'h0F, p[7:0], 8'h01, 32'h0, 8'h00);
            chk("ain", u_host.q, av[p]);
        end
        u_host.frame(8'h0E, 8'h00, 8'h02, 32'h1, 8'h00);
        for (int p = 0; p < 2; p++)
        begin
            u_host.frame(8'h0F, p[7:0], 8'h02, 32'h0, 8'h00);
            chk("dout", u_host.q, p == 0);
        end
        chk("pins", {gen_output_1, gen_output_0}, 2'h1);
        chk("status", u_host.st, 32'h64);
        u_host.xf(1'h0, 8'h28, 32'h0);
        chk("accum", u_host.q, 32'h3);
    endtask
    // traps: 5 not taken, 8 taken
    task t_prog;
        acb_word_t a[3] = '{32'h5, 32'hFFFFFFFF, 32'h0};
        acb_word_t b[3] = '{32'h3, 32'h0, 32'h0};
        logic [11:0] m[3] = '{12'h53A, 12'hACA, 12'h0A5};
        logic [3:0] f[3] = '{4'h5, 4'hA, 4'h0};
        u_host.xf(1'h1, 8'h1C, 32'h3);
        for (int k = 5; k < 9; k += 3)
        begin
            u_host.entry(8'h13, 8'h09, 32'h0);
            u_host.entry(8'h14, 8'h00, 32'h0);
            u_host.entry(8'h15, 8'h02, k);
        end
        for (int p = 0; p < 3; p++)
        begin
            {cond_position_fault, cond_deviation_fault, cond_outside_alarm,
             cond_timeout_fault} <= f[p];
            for (int c = 0; c < 12; c++)
            begin
                u_host.xf(1'h1, 8'h1C, 32'h0);
                u_host.entry(8'h13, 8'h09, a[p]);
                u_host.entry(8'h14, 8'h00, b[p]);
                u_host.entry(8'h15, c[7:0], 32'h6);
                u_host.xf(1'h1, 8'h18, 32'h0);
                u_host.xf(1'h1, 8'h14, 32'h1);
                repeat (40) @(posedge core_clk);
                u_host.xf(1'h0, 8'h18, 32'h0);
                chk("pc", u_host.q, m[p][c] ? 8 : 5);
                u_host.xf(1'h1, 8'h14, 32'h0);
            end
        end
        u_host.xf(1'h0, 8'h2C, 32'h0);
        chk("flags", u_host.q, 32'h3);
    endtask
    // watchdog
    initial
    begin
        #400000 error_cnt++;
        test_done;
    end
    // reset, then scenarios
    initial
    begin
        repeat (4) @(posedge core_clk);
        rst <= 1'h0;
        t_math;
        t_ports;
        t_prog;
        test_done;
    end
endmodule
